// File: rtl/countdown_consts.vh
// Constants for the countdown time generator.
// What this block does
// - Leftmost selector sign picks count direction.
// - Plus preset counts upward after loading.
// - Down count passing zero flips to plus.
// - Start time is seven decimal digits.
// - Display digits: three hours, two minutes, two seconds.
// - Largest count is 999:59:59.
// - Preset halts count, loads sign and time.
// - Hold stops counter, keeps accumulated time.
// - Held display shows hold symbol as sign.
// - Count resumes held value in prior direction.
// - Sign indicator encodes plus, minus, hold.
// - Local/remote selects which panel controls.
// - Time code word carries current time.
// - Each digit drives seven segments.
`ifndef COUNTDOWN_CONSTS_VH
`define COUNTDOWN_CONSTS_VH

`define OFS_CTRL           12'h000
`define OFS_PRESET         12'h004
`define OFS_TIME           12'h008
`define OFS_STATUS         12'h00C
`define CLK_FREQ_HZ        100000000
`define TICK_PERIOD_S      1
`define TICK_CYCLES        (`CLK_FREQ_HZ * `TICK_PERIOD_S)
`define DIGIT_COUNT        7
`define TIME_BITS          28
`define MAX_HOURS_BCD      12'h999
`define MAX_MIN_SEC_BCD    8'h59
`define SIGN_CODE_PLUS     2'h0
`define SIGN_CODE_MINUS    2'h1
`define SIGN_CODE_HOLD     2'h2
`define SEG_PLUS           7'h46
`define SEG_MINUS          7'h40
`define SEG_HOLD           7'h76
`define CODE_SYNC          3'h5

`endif

// File: rtl/bcd_seg_decoder.v
// Seven-segment decoder for one decimal digit.
`timescale 1ns/1ns
`default_nettype none

module bcd_seg_decoder (
    input  wire [3:0] digit,
    output reg  [6:0] segs
);
    // Segment order is g f e d c b a, high means lit.
    always @* begin
        case (digit)
            4'h0:    segs = 7'h3F;
            4'h1:    segs = 7'h06;
            4'h2:    segs = 7'h5B;
            4'h3:    segs = 7'h4F;
            4'h4:    segs = 7'h66;
            4'h5:    segs = 7'h6D;
            4'h6:    segs = 7'h7D;
            4'h7:    segs = 7'h07;
            4'h8:    segs = 7'h7F;
            4'h9:    segs = 7'h6F;
            default: segs = 7'h00;
        endcase
    end
endmodule // bcd_seg_decoder

`default_nettype wire

// File: rtl/countdown_time_generator.v
// Countdown time generator with APB registers and seven-segment outputs.
//
// Register access over APB and the register addresses were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "countdown_consts.vh"

module countdown_time_generator #(
    parameter TICK_CYCLES = `TICK_CYCLES
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output reg  [31:0] prdata,
    output wire        pslverr,
    input  wire        remote_sel,
    input  wire        remote_sign_minus,
    input  wire [27:0] remote_preset_time,
    input  wire        remote_hold,
    input  wire        remote_count,
    input  wire        remote_preset,
    input  wire        local_sign_minus,
    input  wire [27:0] local_preset_time,
    input  wire        local_hold,
    input  wire        local_count,
    input  wire        local_preset,
    output reg  [6:0]  sign_segs,
    output reg  [48:0] digit_segs,
    output reg  [1:0]  sign_code,
    output reg  [31:0] time_code
);

    //------------------------------------------------------------
    // Register map
    //------------------------------------------------------------
    localparam [11:0] ADDR_CTRL   = `OFS_CTRL;
    localparam [11:0] ADDR_PRESET = `OFS_PRESET;
    localparam [11:0] ADDR_TIME   = `OFS_TIME;
    localparam [11:0] ADDR_STATUS = `OFS_STATUS;

    // The counter is either held or running; direction lives in minus_reg.
    localparam [1:0] ST_HELD     = 2'h0;
    localparam [1:0] ST_RUN      = 2'h1;

    //------------------------------------------------------------
    // Registers and state
    //------------------------------------------------------------
    reg  [1:0]  state_reg;
    reg  [1:0]  state_next;
    reg  [27:0] time_reg;
    reg  [27:0] time_next;
    reg         minus_reg;
    reg         minus_next;
    reg  [31:0] tick_cnt_reg;
    reg         tick_reg;
    reg         sw_remote_reg;
    reg         sw_minus_reg;
    reg  [27:0] sw_preset_reg;
    reg         sw_hold_reg;
    reg         sw_count_reg;
    reg         sw_preset_pulse_reg;
    reg         prev_hold_reg;
    reg         prev_count_reg;
    reg         prev_preset_reg;

    wire        apb_write;
    wire        sel_remote;
    wire        src_minus;
    wire [27:0] src_time;
    wire        lvl_hold;
    wire        lvl_count;
    wire        lvl_preset;
    wire        hold_pulse;
    wire        count_pulse;
    wire        preset_pulse;
    wire [27:0] time_inc;
    wire [27:0] time_dec;
    wire        time_zero;
    wire        time_max;
    wire [48:0] seg_wire;

    assign pready    = 1'b1;
    assign pslverr   = 1'b0;
    assign apb_write = psel & penable & pwrite;

    //------------------------------------------------------------
    // Control source selection
    //------------------------------------------------------------
    // Software can force remote panel control in addition to the pin.
    assign sel_remote = remote_sel | sw_remote_reg;
    assign src_minus  = sel_remote ? remote_sign_minus
                                   : (local_sign_minus | sw_minus_reg);
    assign src_time   = sel_remote ? remote_preset_time
                      : ((sw_preset_reg != 28'h0) ? sw_preset_reg
                                                  : local_preset_time);
    assign lvl_hold   = sel_remote ? remote_hold
                                   : (local_hold | sw_hold_reg);
    assign lvl_count  = sel_remote ? remote_count
                                   : (local_count | sw_count_reg);
    assign lvl_preset = sel_remote ? remote_preset
                                   : (local_preset | sw_preset_pulse_reg);

    // Rising edges of the buttons become one-cycle requests.
    assign hold_pulse   = lvl_hold & ~prev_hold_reg;
    assign count_pulse  = lvl_count & ~prev_count_reg;
    assign preset_pulse = lvl_preset & ~prev_preset_reg;

    //------------------------------------------------------------
    // One second tick divider
    //------------------------------------------------------------
    // The tick is a one-cycle enable; nothing else in the block runs
    // slower than pclk.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_reg <= 32'h0;
            tick_reg     <= 1'b0;
        end else if (tick_cnt_reg >= TICK_CYCLES - 1) begin
            tick_cnt_reg <= 32'h0;
            tick_reg     <= 1'b1;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 32'h1;
            tick_reg     <= 1'b0;
        end
    end

    //------------------------------------------------------------
    // BCD step functions
    //------------------------------------------------------------
    function [27:0] bcd_inc;
        input [27:0] t;
        reg   [27:0] r;
        reg          c;
        integer      i;
        begin
            r = t;
            c = 1'b1;
            // Digits 0..6 are s1 s10 m1 m10 h1 h10 h100.
            for (i = 0; i < 7; i = i + 1) begin
                if (c) begin
                    if ((i == 1 || i == 3) && r[i*4 +: 4] == 4'h5) begin
                        r[i*4 +: 4] = 4'h0;
                    end else if (r[i*4 +: 4] == 4'h9) begin
                        r[i*4 +: 4] = 4'h0;
                    end else begin
                        r[i*4 +: 4] = r[i*4 +: 4] + 4'h1;
                        c = 1'b0;
                    end
                end
            end
            bcd_inc = r;
        end
    endfunction

    function [27:0] bcd_dec;
        input [27:0] t;
        reg   [27:0] r;
        reg          b;
        integer      i;
        begin
            r = t;
            b = 1'b1;
            for (i = 0; i < 7; i = i + 1) begin
                if (b) begin
                    if (r[i*4 +: 4] != 4'h0) begin
                        r[i*4 +: 4] = r[i*4 +: 4] - 4'h1;
                        b = 1'b0;
                    end else if (i == 1 || i == 3) begin
                        r[i*4 +: 4] = 4'h5;
                    end else begin
                        r[i*4 +: 4] = 4'h9;
                    end
                end
            end
            bcd_dec = r;
        end
    endfunction

    assign time_inc  = bcd_inc(time_reg);
    assign time_dec  = bcd_dec(time_reg);
    assign time_zero = (time_reg == 28'h0);
    assign time_max  = (time_reg == {`MAX_HOURS_BCD, `MAX_MIN_SEC_BCD,
                                     `MAX_MIN_SEC_BCD});

    //------------------------------------------------------------
    // Count state machine
    //------------------------------------------------------------
    always @* begin
        state_next = state_reg;
        time_next  = time_reg;
        minus_next = minus_reg;
        if (preset_pulse) begin
            state_next = ST_HELD;
            time_next  = src_time;
            minus_next = src_minus;
        end else begin
            case (state_reg)
                ST_HELD: begin
                    // Direction is kept from before the hold.
                    if (count_pulse) begin
                        state_next = ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (hold_pulse) begin
                        state_next = ST_HELD;
                    end else if (tick_reg) begin
                        if (!minus_reg) begin
                            // At full scale the count stays put.
                            if (!time_max) begin
                                time_next = time_inc;
                            end
                        end else if (time_zero) begin
                            // Passing zero turns the count round upward.
                            minus_next = 1'b0;
                            time_next  = time_inc;
                        end else begin
                            time_next = time_dec;
                        end
                    end
                end
                default: begin
                    state_next = ST_HELD;
                end
            endcase
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg       <= ST_HELD;
            time_reg        <= 28'h0;
            minus_reg       <= 1'b0;
            prev_hold_reg   <= 1'b0;
            prev_count_reg  <= 1'b0;
            prev_preset_reg <= 1'b0;
        end else begin
            state_reg       <= state_next;
            time_reg        <= time_next;
            minus_reg       <= minus_next;
            prev_hold_reg   <= lvl_hold;
            prev_count_reg  <= lvl_count;
            prev_preset_reg <= lvl_preset;
        end
    end

    //------------------------------------------------------------
    // APB register file
    //------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sw_remote_reg       <= 1'b0;
            sw_minus_reg        <= 1'b0;
            sw_preset_reg       <= 28'h0;
            sw_hold_reg         <= 1'b0;
            sw_count_reg        <= 1'b0;
            sw_preset_pulse_reg <= 1'b0;
        end else begin
            // Button bits written by software self-clear after one cycle.
            sw_hold_reg         <= 1'b0;
            sw_count_reg        <= 1'b0;
            sw_preset_pulse_reg <= 1'b0;
            if (apb_write) begin
                case (paddr)
                    ADDR_CTRL: begin
                        sw_remote_reg       <= pwdata[0];
                        sw_hold_reg         <= pwdata[1];
                        sw_count_reg        <= pwdata[2];
                        sw_preset_pulse_reg <= pwdata[3];
                    end
                    ADDR_PRESET: begin
                        sw_preset_reg <= pwdata[27:0];
                        sw_minus_reg  <= pwdata[31];
                    end
                    default: begin
                        sw_remote_reg <= sw_remote_reg;
                    end
                endcase
            end
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (psel & ~penable & ~pwrite) begin
            // Data taken in the setup cycle stands through the access.
            case (paddr)
                ADDR_CTRL:   prdata <= {31'h0, sw_remote_reg};
                ADDR_PRESET: prdata <= {sw_minus_reg, 3'h0, sw_preset_reg};
                ADDR_TIME:   prdata <= time_code;
                ADDR_STATUS: prdata <= {28'h0, sel_remote, minus_reg,
                                        sign_code};
                default:     prdata <= 32'h0;
            endcase
        end
    end

    //------------------------------------------------------------
    // Display and time code outputs
    //------------------------------------------------------------
    // Digits decode the next time value so segments move with time_code.
    genvar g;
    generate
        for (g = 0; g < `DIGIT_COUNT; g = g + 1) begin : g_digit
            bcd_seg_decoder u_dec (
                .digit (time_next[g*4 +: 4]),
                .segs  (seg_wire[g*7 +: 7])
            );
        end
    endgenerate

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sign_code  <= `SIGN_CODE_HOLD;
            sign_segs  <= `SEG_HOLD;
            digit_segs <= 49'h0;
            time_code  <= 32'h0;
        end else begin
            digit_segs <= seg_wire;
            // Outputs follow the next state so all change on one edge.
            if (state_next == ST_HELD) begin
                sign_code <= `SIGN_CODE_HOLD;
                sign_segs <= `SEG_HOLD;
            end else if (minus_next) begin
                sign_code <= `SIGN_CODE_MINUS;
                sign_segs <= `SEG_MINUS;
            end else begin
                sign_code <= `SIGN_CODE_PLUS;
                sign_segs <= `SEG_PLUS;
            end
            // Sync pattern, hold flag, seven BCD digits.
            time_code <= {`CODE_SYNC, (state_next == ST_HELD),
                          time_next};
        end
    end

endmodule // countdown_time_generator

`default_nettype wire

// File: verif/countdown_time_generator_asserts.sv
// Concurrent checks on the countdown generator's display and code outputs.
`timescale 1ns/1ns
`default_nettype none
`include "countdown_consts.vh"

module countdown_time_generator_asserts #(
    parameter TICK_CYCLES = 10
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic [6:0]  sign_segs,
    input wire logic [48:0] digit_segs,
    input wire logic [1:0]  sign_code,
    input wire logic [31:0] time_code
);
    wire [27:0] t = time_code[27:0];

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence run_step(c);
        sign_code == c && $past(sign_code) == c && t != $past(t);
    endsequence
    sequence steady_step;
        sign_code != `SIGN_CODE_HOLD && $past(sign_code) != `SIGN_CODE_HOLD
            && t != $past(t);
    endsequence
    sequence at_zero_down;
        sign_code == `SIGN_CODE_MINUS && t == 28'h0;
    endsequence

    hold_glyph_a: assert property (
        sign_code == `SIGN_CODE_HOLD |-> sign_segs == `SEG_HOLD)
        else $error("Hold glyph missing.");
    plus_glyph_a: assert property (
        sign_code == `SIGN_CODE_PLUS |-> sign_segs == `SEG_PLUS)
        else $error("Plus glyph missing.");
    minus_glyph_a: assert property (
        sign_code == `SIGN_CODE_MINUS |-> sign_segs == `SEG_MINUS)
        else $error("Minus glyph missing.");
    code_frame_a: assert property (
        time_code != 32'h0 |-> time_code[31:29] == `CODE_SYNC
            && time_code[28] == (sign_code == `SIGN_CODE_HOLD))
        else $error("Time code frame wrong.");
    step_gap_a: assert property (
        steady_step |=> (sign_code == `SIGN_CODE_HOLD || $stable(t))[*8])
        else $error("Count stepped too soon.");
    down_units_a: assert property (
        run_step(`SIGN_CODE_MINUS) |-> t[3:0] == $past(t[3:0]) - 4'h1
            || ($past(t[3:0]) == 4'h0 && t[3:0] == 4'h9))
        else $error("Down step wrong.");
    up_units_a: assert property (
        run_step(`SIGN_CODE_PLUS) |-> t[3:0] == $past(t[3:0]) + 4'h1
            || ($past(t[3:0]) == 4'h9 && t[3:0] == 4'h0))
        else $error("Up step wrong.");
    zero_cross_a: assert property (
        at_zero_down ##1 steady_step |->
            sign_code == `SIGN_CODE_PLUS && t == 28'h1)
        else $error("Zero crossing wrong.");
    full_scale_a: assert property (
        sign_code == `SIGN_CODE_PLUS && $past(sign_code) == `SIGN_CODE_PLUS
            && $past(t) == 28'h9995959 |-> t == 28'h9995959)
        else $error("Count passed full scale.");
    digit_zero_a: assert property (
        time_code != 32'h0 && t[3:0] == 4'h0 |-> digit_segs[6:0] == 7'h3F)
        else $error("Seconds digit zero glyph wrong.");
endmodule // countdown_time_generator_asserts

bind countdown_time_generator countdown_time_generator_asserts #(
    .TICK_CYCLES(TICK_CYCLES)) u_chk (.pclk(pclk), .presetn(presetn),
    .sign_segs(sign_segs), .digit_segs(digit_segs),
    .sign_code(sign_code), .time_code(time_code));
`default_nettype wire

// File: verif/panel_model.sv
// Operator control panel model: sign wheel, time wheels and push buttons.
`timescale 1ns/1ns
`default_nettype none

module panel_model (
    input  wire logic        clk,
    output logic             sign_minus,
    output logic [27:0]      preset_time,
    output logic [2:0]       buttons
);
    initial begin
        sign_minus = 1'b0;
        preset_time = 28'h0;
        buttons = 3'h0;
    end

    task automatic set_wheels(input logic s, input logic [27:0] t);
        @(posedge clk);
        sign_minus <= s;
        preset_time <= t;
    endtask

    // A press is momentary: buttons {preset, count, hold} go back to idle.
    task automatic press(input logic [2:0] b);
        @(posedge clk);
        buttons <= b;
        repeat (3) @(posedge clk);
        buttons <= 3'h0;
    endtask
endmodule // panel_model
`default_nettype wire

// File: verif/countdown_time_generator_tb.sv
// Self-checking testbench for the countdown time generator.
`timescale 1ns/1ns
`default_nettype none
`include "countdown_consts.vh"

module countdown_time_generator_tb;
    localparam logic [2:0] B_HOLD = 3'h1;
    localparam logic [2:0] B_COUNT = 3'h2;
    localparam logic [2:0] B_PRESET = 3'h4;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        remote_sel, r_minus, l_minus;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, time_code;
    logic [27:0] r_time, l_time;
    logic [2:0]  r_btn, l_btn;
    logic [6:0]  sign_segs;
    logic [48:0] digit_segs;
    logic [1:0]  sign_code;
    logic [6:0]  seg_tab [7] = '{7'h7F, 7'h3F, 7'h6D, 7'h66, 7'h4F, 7'h5B,
                                7'h06};
    int          err_total, checked;

    panel_model rp (.clk(pclk), .sign_minus(r_minus), .preset_time(r_time),
        .buttons(r_btn));
    panel_model lp (.clk(pclk), .sign_minus(l_minus), .preset_time(l_time),
        .buttons(l_btn));
    countdown_time_generator #(.TICK_CYCLES(10)) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .remote_sel(remote_sel),
        .remote_sign_minus(r_minus), .remote_preset_time(r_time),
        .remote_hold(r_btn[0]), .remote_count(r_btn[1]),
        .remote_preset(r_btn[2]), .local_sign_minus(l_minus),
        .local_preset_time(l_time), .local_hold(l_btn[0]),
        .local_count(l_btn[1]), .local_preset(l_btn[2]),
        .sign_segs(sign_segs), .digit_segs(digit_segs),
        .sign_code(sign_code), .time_code(time_code));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic sgn(input logic [1:0] e);
        chk("sign", {30'h0, sign_code}, {30'h0, e});
    endtask

    // Checks a held count now and again after three count periods.
    task automatic hold_at(input logic [27:0] t);
        @(negedge pclk);
        sgn(`SIGN_CODE_HOLD);
        chk("glyph", {25'h0, sign_segs}, {25'h0, `SEG_HOLD});
        repeat (30) @(negedge pclk);
        chk("held", time_code, {4'hB, t});
    endtask

    task automatic step(input logic [1:0] sc, input logic [27:0] t);
        logic [27:0] was;
        int n;
        was = time_code[27:0];
        n = 0;
        while (time_code[27:0] === was && n < 100) begin
            @(negedge pclk);
            n++;
        end
        if (n >= 100) begin
            err_total++;
            test_done();
        end
        chk("count", time_code, {4'hA, t});
        sgn(sc);
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 50) begin
            err_total++;
            test_done();
        end
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        chk("slverr", {31'h0, pslverr}, 32'h0);
    endtask

    task automatic test_done;
        $display("checks %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Clock, watchdog and tests
    // ------------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    initial begin
        #100000;
        err_total++;
        test_done();
    end

    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        remote_sel = 1'b1;
        presetn = 1'b0;
        err_total = 0;
        checked = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        sgn(`SIGN_CODE_HOLD);
        rp.set_wheels(1'b0, 28'h0005958);
        rp.press(B_PRESET);
        hold_at(28'h0005958);
        rp.press(B_COUNT);
        step(`SIGN_CODE_PLUS, 28'h0005959);
        step(`SIGN_CODE_PLUS, 28'h0010000);
        rp.press(B_HOLD);
        hold_at(28'h0010000);
        rp.set_wheels(1'b1, 28'h0000003);
        rp.press(B_PRESET);
        hold_at(28'h0000003);
        rp.press(B_COUNT);
        step(`SIGN_CODE_MINUS, 28'h0000002);
        rp.press(B_HOLD);
        hold_at(28'h0000002);
        rp.press(B_COUNT);
        step(`SIGN_CODE_MINUS, 28'h0000001);
        step(`SIGN_CODE_MINUS, 28'h0000000);
        step(`SIGN_CODE_PLUS, 28'h0000001);
        rp.set_wheels(1'b0, 28'h9995958);
        rp.press(B_PRESET);
        hold_at(28'h9995958);
        rp.press(B_COUNT);
        step(`SIGN_CODE_PLUS, 28'h9995959);
        repeat (40) @(negedge pclk);
        chk("max", time_code, {4'hA, 28'h9995959});
        rp.set_wheels(1'b0, 28'h1234508);
        rp.press(B_PRESET);
        hold_at(28'h1234508);
        for (int k = 0; k < 7; k++)
            chk("digit", {25'h0, digit_segs[7*k +: 7]},
                {25'h0, seg_tab[k]});
        rp.press(B_PRESET | B_COUNT);
        hold_at(28'h1234508);
        @(posedge pclk);
        remote_sel <= 1'b0;
        lp.set_wheels(1'b1, 28'h0000100);
        rp.set_wheels(1'b0, 28'h0000200);
        rp.press(B_PRESET);
        hold_at(28'h1234508);
        lp.press(B_PRESET);
        hold_at(28'h0000100);
        apb(1'b0, 12'h00C, 32'h0);
        chk("status", {28'h0, rd[3:0]}, 32'h6);
        apb(1'b0, 12'h008, 32'h0);
        chk("tcode", rd, {4'hB, 28'h0000100});
        apb(1'b1, 12'h004, 32'h80000042);
        apb(1'b0, 12'h004, 32'h0);
        chk("preset", rd, 32'h80000042);
        apb(1'b1, 12'h010, 32'hFFFFFFFF);
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped", rd, 32'h0);
        apb(1'b1, 12'h000, 32'h8);
        repeat (2) @(negedge pclk);
        hold_at(28'h0000042);
        apb(1'b1, 12'h000, 32'h4);
        repeat (3) @(negedge pclk);
        sgn(`SIGN_CODE_MINUS);
        apb(1'b1, 12'h000, 32'h2);
        repeat (2) @(negedge pclk);
        sgn(`SIGN_CODE_HOLD);
        apb(1'b1, 12'h000, 32'h1);
        apb(1'b0, 12'h000, 32'h0);
        chk("ctrl", rd, 32'h1);
        apb(1'b0, 12'h00C, 32'h0);
        chk("status", {28'h0, rd[3:0]}, 32'hE);
        test_done();
    end
endmodule // countdown_time_generator_tb
`default_nettype wire
